// ### shared/stsp_pkg.sv
package stsp_pkg;

  // Word format
  localparam int unsigned STSP_SAMPLE_W   = 13;          // Bits per sample word
  localparam int unsigned STSP_SAMPLE_HZ  = 8000;        // Words per second
  // Clocking
  localparam int unsigned STSP_MCLK_HZ    = 125_000_000; // Local clock rate
  localparam int unsigned STSP_BIT_KHZ    = 104;         // Link bit clock, kHz
  localparam int unsigned STSP_BIT_HZ     = STSP_BIT_KHZ * 1000;
  // Bit period in local cycles, nearest whole count
  localparam int unsigned STSP_BIT_CYC    = (STSP_MCLK_HZ + STSP_BIT_HZ / 2) / STSP_BIT_HZ;
  // Least reset pulse
  localparam int unsigned STSP_RST_MIN_MS = 4;
  localparam int unsigned STSP_RST_MIN_CYC = (STSP_MCLK_HZ / 1000) * STSP_RST_MIN_MS;
  // Mode settle time before reset, strictly more than this
  localparam int unsigned STSP_SETTLE_S   = 1;
  localparam int unsigned STSP_SETTLE_CYC = STSP_MCLK_HZ * STSP_SETTLE_S + 1;

  // Mode codes as {line 1, line 2}
  localparam logic [1:0] STSP_MODE_NORMAL   = 2'h0; // Internal routing
  localparam logic [1:0] STSP_MODE_DOWNLINK = 2'h1; // Decoder test
  localparam logic [1:0] STSP_MODE_UPLINK   = 2'h2; // Encoder test
  localparam logic [1:0] STSP_MODE_ACOUSTIC = 2'h3; // Converter test

endpackage : stsp_pkg

// ### shared/stsp_if.sv
`timescale 1ns/100ps
// Speech test port wires between handset and tester
interface stsp_if;
  logic bit_clk;  // Bit clock, handset drives, idle high
  logic hs_data;  // Data from handset
  logic tst_data; // Data from tester
  logic mode1;    // Mode select line 1
  logic mode2;    // Mode select line 2
  logic rst_n;    // Test reset, active low

  // Handset end
  modport handset (
    output bit_clk,
    output hs_data,
    input  tst_data,
    input  mode1,
    input  mode2,
    input  rst_n
  );

  // Tester end
  modport tester (
    input  bit_clk,
    input  hs_data,
    output tst_data,
    output mode1,
    output mode2,
    output rst_n
  );
endinterface : stsp_if

// ### rtl/stsp_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser, one per bit
module stsp_sync #(
  parameter int unsigned W    = 1,   // Number of bits
  parameter logic [W-1:0] INIT = '0  // Value under reset
) (
  input  wire logic         i_clk, // Destination clock
  input  wire logic         i_rst, // Synchronous reset
  input  wire logic [W-1:0] i_d,   // Asynchronous input
  output logic      [W-1:0] o_q    // Synchronised output
);

  typedef struct packed {
    logic [W-1:0] s1; // First stage, read by s2 only
    logic [W-1:0] s2; // Second stage
  } stsp_sync_s;

  stsp_sync_s q;
  stsp_sync_s n;

  // Next stage values
  always_comb begin
    n.s1 = i_d;
    n.s2 = q.s1;
  end

  // Stage registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '{s1: INIT, s2: INIT};
    end else begin
      q <= n;
    end
  end

  assign o_q = q.s2;

endmodule : stsp_sync

// ### rtl/stsp_tester.sv
`timescale 1ns/100ps
// Tester end: sets mode, resets the handset, streams words both ways
module stsp_tester
  import stsp_pkg::*;
#(
  parameter int unsigned SETTLE  = STSP_SETTLE_CYC,  // Mode settle, cycles
  parameter int unsigned RST_MIN = STSP_RST_MIN_CYC  // Reset pulse, cycles
) (
  input  wire logic                     i_mclk,     // Local clock
  input  wire logic                     i_rst,      // Sync reset, high
  stsp_if.tester                        link,       // Port wires
  input  wire logic [1:0]               i_mode,     // Mode to set
  input  wire logic                     i_start,    // Start test pulse
  input  wire logic [STSP_SAMPLE_W-1:0] i_tx_word,  // Next word to send
  output logic                          o_tx_taken, // Word captured pulse
  output logic      [STSP_SAMPLE_W-1:0] o_rx_word,  // Received word
  output logic                          o_rx_valid, // Received pulse
  output logic                          o_busy      // Test launched
);

  localparam int unsigned W  = STSP_SAMPLE_W;
  localparam int unsigned CW = $clog2(((SETTLE > RST_MIN) ? SETTLE : RST_MIN) + 1);
  localparam logic [CW-1:0] SET_END = CW'(SETTLE - 1);
  localparam logic [CW-1:0] RST_END = CW'(RST_MIN - 1);
  localparam logic [3:0]    LAST    = 4'(W - 1);

  // Parameter sanity
  if (SETTLE < 2 || RST_MIN < 2 || W > 16) begin : g_bad_param
    $error("stsp_tester: unsupported parameter values");
  end

  typedef enum logic [1:0] {T_IDLE, T_SETTLE, T_RESET, T_TEST} stsp_tst_state_e;

  typedef struct packed {
    stsp_tst_state_e st;       // Sequencer state
    logic [1:0]      mode;     // Mode lines
    logic [CW-1:0]   cnt;      // Time counter
    logic            rst_n;    // Reset line
    logic            link_rst; // Link side reset
    logic [W-1:0]    hold;     // Word for link side
    logic            tk_seen;  // Last taken toggle
    logic            rx_seen;  // Last receive toggle
    logic [W-1:0]    rx_word;  // Received word
    logic            rx_valid; // Receive pulse
    logic            tx_taken; // Taken pulse
    logic            busy;     // Test launched
  } stsp_tst_s;

  localparam stsp_tst_s TST_RST = '{st: T_IDLE, mode: STSP_MODE_NORMAL, cnt: '0,
                                    rst_n: 1'b1, link_rst: 1'b1, hold: '0,
                                    tk_seen: 1'b0, rx_seen: 1'b0, rx_word: '0,
                                    rx_valid: 1'b0, tx_taken: 1'b0, busy: 1'b0};

  stsp_tst_s q;
  stsp_tst_s n;

  // Link side state, clocked by the handset's bit clock
  logic [3:0]   lk_bit;   // Bit index in word
  logic [W-1:0] lk_sh;    // Word being sent
  logic [W-1:0] lk_rx_sh; // Receive shifter
  logic [W-1:0] lk_rx;    // Last whole word
  logic         lk_rx_t;  // Word received toggle
  logic         lk_tk_t;  // Word taken toggle
  logic         lk_dout;  // Data line register
  logic [1:0]   tog_s;    // Synchronised toggles

  // Toggles into the local domain
  stsp_sync #(.W(2), .INIT(2'h0)) u_sync (
    .i_clk (i_mclk),
    .i_rst (i_rst),
    .i_d   ({lk_tk_t, lk_rx_t}),
    .o_q   (tog_s)
  );

  // Sequencer and word hand-off
  always_comb begin
    n = q;
    n.rx_valid = 1'b0;
    n.tx_taken = 1'b0;
    case (q.st)
      T_IDLE: begin
        n.cnt = '0;
      end
      T_SETTLE: begin
        if (q.cnt == SET_END) begin
          n.st    = T_RESET;
          n.cnt   = '0;
          n.rst_n = 1'b0;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      T_RESET: begin
        if (q.cnt == RST_END) begin
          n.st       = T_TEST;
          n.rst_n    = 1'b1;
          n.hold     = i_tx_word;
          n.tx_taken = 1'b1;
        end else begin
          n.cnt = q.cnt + 1'b1;
        end
      end
      T_TEST: begin
        // Reload when link side took the word
        if (tog_s[1] != q.tk_seen) begin
          n.hold     = i_tx_word;
          n.tx_taken = 1'b1;
        end
        // Capture a finished word
        if (tog_s[0] != q.rx_seen) begin
          n.rx_word  = lk_rx;
          n.rx_valid = 1'b1;
        end
      end
      default: begin
        n.st = T_IDLE;
      end
    endcase
    n.tk_seen = tog_s[1];
    n.rx_seen = tog_s[0];
    if (i_start) begin
      n.st    = T_SETTLE;
      n.mode  = i_mode;
      n.cnt   = '0;
      n.rst_n = 1'b1;
      n.busy  = 1'b1;
    end
    n.link_rst = ~n.rst_n;
  end

  // Local registers
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= TST_RST;
    end else begin
      q <= n;
    end
  end

  always_ff @(posedge link.bit_clk or posedge q.link_rst) begin
    if (q.link_rst) begin
      lk_bit   <= 4'h0;
      lk_sh    <= '0;
      lk_rx_sh <= '0;
      lk_rx    <= '0;
      lk_rx_t  <= 1'b0;
      lk_tk_t  <= 1'b0;
    end else begin
      lk_rx_sh <= {lk_rx_sh[W-2:0], link.hs_data};
      // Hold stays still until the taken toggle crosses
      if (lk_bit == 4'h0) begin
        lk_sh   <= q.hold;
        lk_tk_t <= ~lk_tk_t;
      end
      if (lk_bit == LAST) begin
        lk_bit  <= 4'h0;
        lk_rx   <= {lk_rx_sh[W-2:0], link.hs_data};
        lk_rx_t <= ~lk_rx_t;
      end else begin
        lk_bit <= lk_bit + 4'h1;
      end
    end
  end

  // launch own data on fall, MSB first
  always_ff @(negedge link.bit_clk or posedge q.link_rst) begin
    if (q.link_rst) begin
      lk_dout <= 1'b0;
    end else if (lk_bit == 4'h0) begin
      lk_dout <= q.hold[W-1];
    end else begin
      lk_dout <= lk_sh[LAST - lk_bit];
    end
  end

  assign link.tst_data = lk_dout;
  assign link.mode1    = q.mode[1];
  assign link.mode2    = q.mode[0];
  assign link.rst_n    = q.rst_n;
  assign o_tx_taken    = q.tx_taken;
  assign o_rx_word     = q.rx_word;
  assign o_rx_valid    = q.rx_valid;
  assign o_busy        = q.busy;

endmodule : stsp_tester

// ### rtl/stsp_handset.sv
`timescale 1ns/100ps
// Functional notes
// - 8000 words/s at 104 kbit/s, duplex
// - 13-bit two's complement, MSB first
// - Handset makes gated 104 kHz clock
// - Clock line high while idle
// - Launch on falling edge, sample on rising
// - Tester drives mode and reset lines
// - Reset active low, at least 4 ms
// - Reset clears transcoder and converters
// - Mode lines decode four routings
// - Mode taken from lines, not messages
// - Tester waits over 1 s before reset
// - Clocking starts after reset release
// - Uplink starts at next block frame
// - Downlink starts after first finished block
// - Release in test mode restarts transcoders
// - Test mode breaks normal speech paths
module stsp_handset
  import stsp_pkg::*;
#(
  parameter int unsigned RST_MIN = STSP_RST_MIN_CYC, // Least reset, cycles
  parameter int unsigned BIT_CYC = STSP_BIT_CYC      // Bit period, cycles
) (
  input  wire logic                     i_mclk,           // Local clock
  input  wire logic                     i_rst,            // Sync reset, high
  stsp_if.handset                       link,             // Port wires
  input  wire logic [STSP_SAMPLE_W-1:0] i_tx_word,        // Word to send
  input  wire logic                     i_tx_valid,       // Downlink word ready
  input  wire logic                     i_block_frame,    // Block frame start
  input  wire logic                     i_block_done,     // Block received
  output logic                          o_tx_taken,       // Word loaded pulse
  output logic      [STSP_SAMPLE_W-1:0] o_rx_word,        // Word from tester
  output logic                          o_rx_valid,       // Word pulse
  output logic      [1:0]               o_mode,           // Decoded mode
  output logic                          o_test_active,    // Paths rerouted
  output logic                          o_codec_rst,      // Codec reset level
  output logic                          o_xcoder_restart  // Restart pulse
);

  localparam int unsigned W  = STSP_SAMPLE_W;
  localparam int unsigned CW = $clog2(BIT_CYC);
  localparam int unsigned RW = $clog2(RST_MIN + 1);
  localparam logic [CW-1:0] DIV_RISE = CW'(BIT_CYC / 2);
  localparam logic [CW-1:0] DIV_END  = CW'(BIT_CYC - 1);
  localparam logic [RW-1:0] RCNT_MAX = RW'(RST_MIN);
  localparam logic [3:0]    BIT_LAST = 4'(W - 1);

  // Parameter sanity
  if (BIT_CYC < 4 || RST_MIN < 1 || W > 16) begin : g_bad_param
    $error("stsp_handset: unsupported parameter values");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} stsp_hs_state_e;

  typedef struct packed {
    stsp_hs_state_e st;          // Link state
    logic [1:0]     mode;        // Decoded mode
    logic           test_active; // Test routing
    logic [RW-1:0]  rcnt;        // Reset low time
    logic [CW-1:0]  div;         // Bit period phase
    logic [3:0]     bit_i;       // Bit index
    logic [W-1:0]   tx_sh;       // Outgoing shifter
    logic [W-1:0]   rx_sh;       // Incoming shifter
    logic           clk;         // Bit clock line
    logic           dout;        // Data line
    logic [W-1:0]   rx_word;     // Last word in
    logic           rx_valid;    // Word pulse
    logic           tx_taken;    // Load pulse
    logic           codec_rst;   // Codec reset
    logic           restart;     // Restart pulse
  } stsp_hs_s;

  localparam stsp_hs_s HS_RST = '{st: ST_IDLE, mode: STSP_MODE_NORMAL,
                                  test_active: 1'b0, rcnt: '0, div: '0,
                                  bit_i: 4'h0, tx_sh: '0, rx_sh: '0,
                                  clk: 1'b1, dout: 1'b0, rx_word: '0,
                                  rx_valid: 1'b0, tx_taken: 1'b0,
                                  codec_rst: 1'b0, restart: 1'b0};

  stsp_hs_s q;
  stsp_hs_s n;

  logic [3:0] pins_s; // Synchronised tester lines
  logic       s_mode1;
  logic       s_mode2;
  logic       s_rst_n;
  logic       s_data;

  // Tester lines into the local domain
  stsp_sync #(.W(4), .INIT(4'h2)) u_sync (
    .i_clk (i_mclk),
    .i_rst (i_rst),
    .i_d   ({link.mode1, link.mode2, link.rst_n, link.tst_data}),
    .o_q   (pins_s)
  );

  assign s_mode1 = pins_s[3];
  assign s_mode2 = pins_s[2];
  assign s_rst_n = pins_s[1];
  assign s_data  = pins_s[0];

  // Next state of the whole handset end
  always_comb begin
    n = q;
    n.rx_valid = 1'b0;
    n.tx_taken = 1'b0;
    n.restart  = 1'b0;
    // line 1 is the upper bit
    n.mode = {s_mode1, s_mode2};
    n.test_active = (n.mode != STSP_MODE_NORMAL);
    case (q.st)
      // No clocking
      ST_IDLE: begin
        n.clk = 1'b1;
      end
      // Waiting for the start point of the mode
      ST_ARMED: begin
        n.clk   = 1'b1;
        n.div   = '0;
        n.bit_i = 4'h0;
        if (q.mode == STSP_MODE_UPLINK && i_block_frame) begin
          n.st = ST_RUN;
        end
        if (q.mode == STSP_MODE_DOWNLINK && i_block_done) begin
          n.st = ST_RUN;
        end
        // Converter test starts at once
        if (q.mode == STSP_MODE_ACOUSTIC) begin
          n.st = ST_RUN;
        end
      end
      // Streaming words
      ST_RUN: begin
        if (q.div == '0) begin
          if (q.bit_i == 4'h0) begin
            // downlink clocks only with a word to move, other modes always
            if (q.mode != STSP_MODE_DOWNLINK || i_tx_valid) begin
              // first bit out on falling edge
              n.clk      = 1'b0;
              n.dout     = i_tx_word[W-1];
              n.tx_sh    = {i_tx_word[W-2:0], 1'b0};
              n.tx_taken = 1'b1;
              n.div      = q.div + 1'b1;
            end
          end else begin
            n.clk   = 1'b0;
            n.dout  = q.tx_sh[W-1];
            n.tx_sh = {q.tx_sh[W-2:0], 1'b0};
            n.div   = q.div + 1'b1;
          end
        end else if (q.div == DIV_RISE) begin
          // sample tester data on rising edge
          n.clk   = 1'b1;
          n.rx_sh = {q.rx_sh[W-2:0], s_data};
          n.div   = q.div + 1'b1;
          if (q.bit_i == BIT_LAST) begin
            n.bit_i    = 4'h0;
            n.rx_word  = {q.rx_sh[W-2:0], s_data};
            n.rx_valid = 1'b1;
          end else begin
            n.bit_i = q.bit_i + 4'h1;
          end
        end else if (q.div == DIV_END) begin
          // 1202 cycles per bit gives 104 kbit/s
          n.div = '0;
        end else begin
          n.div = q.div + 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    if (n.mode == STSP_MODE_NORMAL) begin
      n.st    = ST_IDLE;
      n.clk   = 1'b1;
      n.div   = '0;
      n.bit_i = 4'h0;
    end
    if (!s_rst_n) begin
      n.codec_rst = 1'b1;
      n.st        = ST_IDLE;
      n.clk       = 1'b1;
      n.div       = '0;
      n.bit_i     = 4'h0;
      if (q.rcnt != RCNT_MAX) begin
        n.rcnt = q.rcnt + 1'b1;
      end
    end else begin
      n.codec_rst = 1'b0;
      n.rcnt      = '0;
      if (q.codec_rst && n.mode != STSP_MODE_NORMAL) begin
        n.restart = 1'b1;
        // long enough pulse arms the test
        if (q.rcnt == RCNT_MAX) begin
          n.st = ST_ARMED;
        end
      end
    end
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      q <= HS_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from state
  assign link.bit_clk     = q.clk;
  assign link.hs_data     = q.dout;
  assign o_tx_taken       = q.tx_taken;
  assign o_rx_word        = q.rx_word;
  assign o_rx_valid       = q.rx_valid;
  assign o_mode           = q.mode;
  assign o_test_active    = q.test_active;
  assign o_codec_rst      = q.codec_rst;
  assign o_xcoder_restart = q.restart;

endmodule : stsp_handset

// ### dv/stsp_link_properties.sv
`timescale 1ns/100ps
// Watches the port wires on the local clock
module stsp_link_properties #(
  parameter int unsigned SETTLE  = 50, // Mode settle, cycles
  parameter int unsigned RST_MIN = 48, // Reset width, cycles
  parameter int unsigned BIT_CYC = 12  // Bit period, cycles
) (
  input wire logic i_mclk,   // Local clock
  input wire logic i_rst,    // Sync reset, high
  input wire logic bit_clk,  // Link bit clock
  input wire logic hs_data,  // Handset data
  input wire logic tst_data, // Tester data
  input wire logic mode1,    // Mode line 1
  input wire logic mode2,    // Mode line 2
  input wire logic rst_n     // Test reset
);
  logic [31:0] lo_q;   // Low phase length
  logic [31:0] hi_q;   // High phase length
  logic [31:0] set_q;  // Cycles since mode moved, less one
  logic [31:0] rl_q;   // Reset pulse length
  logic [1:0]  m_q;    // Last mode lines
  logic        test_w; // A test mode is set
  assign test_w = mode1 | mode2;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      lo_q  <= 32'h0;
      hi_q  <= 32'h0;
      set_q <= 32'h0;
      rl_q  <= 32'h0;
      m_q   <= 2'h0;
    end else begin
      lo_q  <= bit_clk ? 32'h0 : lo_q + 32'h1;
      hi_q  <= bit_clk ? hi_q + 32'h1 : 32'h0;
      set_q <= ({mode1, mode2} != m_q) ? 32'h0 : set_q + 32'h1;
      rl_q  <= rst_n ? 32'h0 : rl_q + 32'h1;
      m_q   <= {mode1, mode2};
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Release of reset in converter test mode
  sequence s_acu_release;
    $rose(rst_n) && mode1 && mode2;
  endsequence
  // First bit requested soon after
  sequence s_first_fall;
    ##[2:12] !bit_clk;
  endsequence

  property p_low_phase;
    disable iff (i_rst || !rst_n || !test_w) $rose(bit_clk) |-> lo_q == BIT_CYC / 2;
  endproperty
  a_low_phase: assert property (p_low_phase) else $error("bit clock low phase wrong");
  property p_high_phase;
    $fell(bit_clk) |-> hi_q >= BIT_CYC / 2;
  endproperty
  a_high_phase: assert property (p_high_phase) else $error("bit clock high too short");
  property p_idle_reset;
    !rst_n [*5] |-> bit_clk;
  endproperty
  a_idle_reset: assert property (p_idle_reset) else $error("clock runs in reset");
  property p_idle_normal;
    !test_w [*5] |-> bit_clk;
  endproperty
  a_idle_normal: assert property (p_idle_normal) else $error("clock runs in normal");
  property p_rst_width;
    $rose(rst_n) |-> rl_q >= RST_MIN;
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse too short");
  property p_settle;
    $fell(rst_n) |-> set_q >= SETTLE - 1;
  endproperty
  a_settle: assert property (p_settle) else $error("reset before mode settled");
  property p_mode_hold;
    !rst_n |-> $stable({mode1, mode2});
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved in reset");
  property p_acu_start;
    s_acu_release |-> s_first_fall;
  endproperty
  a_acu_start: assert property (p_acu_start) else $error("no clock after release");
  property p_tst_launch;
    $changed(tst_data) && rst_n && $past(rst_n) |-> !bit_clk;
  endproperty
  a_tst_launch: assert property (p_tst_launch) else $error("tester data moved high");
  property p_hs_launch;
    $changed(hs_data) && rst_n && test_w |-> $fell(bit_clk);
  endproperty
  a_hs_launch: assert property (p_hs_launch) else $error("handset data off fall");
endmodule : stsp_link_properties

// ### dv/tb.sv
`timescale 1ns/100ps
// Bench: handset and tester joined, plus a lone handset for bad resets
module tb;
  import stsp_pkg::*;
  localparam int unsigned SETTLE = 50; // Short mode settle
  localparam int unsigned RST_T  = 48; // Tester reset width
  localparam int unsigned RST_H  = 40; // Handset least reset
  localparam int unsigned BITC   = 12; // Short bit period
  // One run and the words it swaps
  typedef struct packed {
    logic [1:0]               mode; // Mode to set
    logic [STSP_SAMPLE_W-1:0] hw;   // Handset word
    logic [STSP_SAMPLE_W-1:0] tw;   // Tester word
  } stsp_row_s;
  logic                     i_mclk;      // Local clock
  logic                     i_rst;       // Sync reset
  logic [1:0]               t_mode;      // Tester mode
  logic                     t_start;     // Tester start
  logic [STSP_SAMPLE_W-1:0] t_txw;       // Tester word out
  logic [STSP_SAMPLE_W-1:0] t_rxw;       // Tester word in
  logic                     t_rxv;       // Tester word pulse
  logic                     t_busy;      // Tester launched
  logic [STSP_SAMPLE_W-1:0] h_txw;       // Handset word out
  logic                     h_txv;       // Handset word ready
  logic                     h_frame;     // Block frame pulse
  logic                     h_done;      // Block done pulse
  logic [STSP_SAMPLE_W-1:0] h_rxw;       // Handset word in
  logic                     h_rxv;       // Handset word pulse
  logic [1:0]               h_mode;      // Decoded mode
  logic                     h_act;       // Test paths on
  logic                     h_crst;      // Codec reset
  logic                     h_rstrt;     // Restart pulse
  logic                     h_tk;        // Handset word loaded
  logic                     t_tk;        // Tester word captured
  int                       n_htk = 0;   // Handset loads seen
  int                       n_ttk = 0;   // Tester captures seen
  int                       miscompares; // Mismatches
  int                       n_checks;    // Compares made
  int                       i;           // Row index
  int                       k;           // Wait count
  logic                     lo;          // Clock seen low
  stsp_row_s                rows [5];    // Ordinary runs
  stsp_if lf ();
  stsp_if lf2 ();

  stsp_handset #(.RST_MIN(RST_H), .BIT_CYC(BITC)) stsp_handset_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .link(lf), .i_tx_word(h_txw), .i_tx_valid(h_txv),
    .i_block_frame(h_frame), .i_block_done(h_done), .o_tx_taken(h_tk), .o_rx_word(h_rxw),
    .o_rx_valid(h_rxv), .o_mode(h_mode), .o_test_active(h_act), .o_codec_rst(h_crst),
    .o_xcoder_restart(h_rstrt));
  stsp_tester #(.SETTLE(SETTLE), .RST_MIN(RST_T)) stsp_tester_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .link(lf), .i_mode(t_mode), .i_start(t_start),
    .i_tx_word(t_txw), .o_tx_taken(t_tk), .o_rx_word(t_rxw), .o_rx_valid(t_rxv),
    .o_busy(t_busy));
  // Lone handset whose reset line the bench drives
  stsp_handset #(.RST_MIN(RST_H), .BIT_CYC(BITC)) stsp_handset_lone_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .link(lf2), .i_tx_word(h_txw), .i_tx_valid(h_txv),
    .i_block_frame(h_frame), .i_block_done(h_done), .o_tx_taken(), .o_rx_word(),
    .o_rx_valid(), .o_mode(), .o_test_active(), .o_codec_rst(), .o_xcoder_restart());
  stsp_link_properties #(.SETTLE(SETTLE), .RST_MIN(RST_T), .BIT_CYC(BITC)) u_chk (
    .i_mclk(i_mclk), .i_rst(i_rst), .bit_clk(lf.bit_clk), .hs_data(lf.hs_data),
    .tst_data(lf.tst_data), .mode1(lf.mode1), .mode2(lf.mode2), .rst_n(lf.rst_n));

  // Local clock
  always #4 i_mclk = ~i_mclk;

  // Count word hand-off pulses of both ends
  always @(posedge i_mclk) begin
    if (h_tk === 1'b1) n_htk <= n_htk + 1;
    if (t_tk === 1'b1) n_ttk <= n_ttk + 1;
  end

  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Step past edges, then settle
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask : tick

  // Verdict and end of run
  task automatic test_done();
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done

  // Bounded wait for a test reset level
  task automatic wait_rst(input logic lvl);
    int n;
    for (n = 0; n < 400 && lf.rst_n !== lvl; n++) tick(1);
    if (n == 400) begin
      miscompares++;
      test_done();
    end
  endtask : wait_rst

  // One full test start and word swap
  task automatic run_row(input stsp_row_s r);
    int n;
    logic gh;
    logic gt;
    logic rs;
    int h0;
    int t0;
    h_txw = r.hw;
    t_txw = r.tw;
    h_txv = 1'b0;
    t_mode = r.mode;
    t_start = 1'b1;
    tick(1);
    t_start = 1'b0;
    wait_rst(1'b0);
    h0 = n_htk;
    t0 = n_ttk;
    tick(5);
    check("codec_rst", h_crst, 16'h1);
    wait_rst(1'b1);
    rs = 1'b0;
    for (n = 0; n < 10; n++) begin
      tick(1);
      rs = rs | h_rstrt;
    end
    check("restart", rs, r.mode != 2'h0);
    tick(40);
    if (r.mode != 2'h3) check("gated_clk", lf.bit_clk, 16'h1);
    check("mode", h_mode, r.mode);
    check("active", h_act, r.mode != 2'h0);
    h_frame = 1'b1;
    h_done = 1'b1;
    h_txv = 1'b1;
    tick(1);
    h_frame = 1'b0;
    h_done = 1'b0;
    gh = 1'b0;
    gt = 1'b0;
    for (n = 0; n < 600 && !(gh && gt); n++) begin
      tick(1);
      if (h_rxv === 1'b1 && !gh) begin
        gh = 1'b1;
        check("hs_rx", h_rxw, r.tw);
      end
      if (t_rxv === 1'b1 && !gt) begin
        gt = 1'b1;
        check("tst_rx", t_rxw, r.hw);
      end
    end
    check("words", {gh, gt}, (r.mode != 2'h0) ? 16'h3 : 16'h0);
    check("hs_taken", n_htk != h0, r.mode != 2'h0);
    check("tst_taken", n_ttk - t0 > 1, r.mode != 2'h0);
  endtask : run_row

  // Main sequence
  initial begin
    i_mclk = 1'b0;
    i_rst = 1'b1;
    {t_mode, t_start, t_txw, h_txw, h_txv, h_frame, h_done} = '0;
    miscompares = 0;
    n_checks = 0;
    lf2.mode1 = 1'b1;
    lf2.mode2 = 1'b1;
    lf2.rst_n = 1'b1;
    lf2.tst_data = 1'b0;
    rows = '{'{2'h1, 13'h1000, 13'h0FFF}, '{2'h2, 13'h0FFF, 13'h1000},
             '{2'h3, 13'h1555, 13'h0AAA}, '{2'h0, 13'h0001, 13'h1FFE},
             '{2'h3, 13'h0001, 13'h1FFE}};
    tick(10);
    check("idle_clk", lf.bit_clk, 16'h1);
    check("idle_rst", lf.rst_n, 16'h1);
    check("idle_mode", h_mode, 16'h0);
    tick(6);
    i_rst = 1'b0;
    tick(2);
    for (i = 0; i < 5; i++) run_row(rows[i]);
    check("busy", t_busy, 16'h1);
    lf2.rst_n = 1'b0;
    tick(RST_H - 10);
    lf2.rst_n = 1'b1;
    lo = 1'b0;
    for (k = 0; k < 60; k++) begin
      tick(1);
      lo = lo | !lf2.bit_clk;
    end
    check("short_rst", lo, 16'h0);
    lf2.rst_n = 1'b0;
    tick(RST_H + 4);
    lf2.rst_n = 1'b1;
    for (k = 0; k < 20 && lf2.bit_clk !== 1'b0; k++) tick(1);
    check("full_rst", lf2.bit_clk, 16'h0);
    // Mid-run reset sends both ends back to idle
    i_rst = 1'b1;
    tick(3);
    i_rst = 1'b0;
    tick(2);
    check("rst_clk", lf2.bit_clk, 16'h1);
    check("rst_busy", t_busy, 16'h0);
    check("rst_line", lf.rst_n, 16'h1);
    test_done();
  end
endmodule : tb
